// ### common/rucs_defs.svh
/*
  Constants for the remote update configuration sequencer.
  Assumes inclusion by bare name from the design file.
*/
`ifndef RUCS_DEFS_SVH
`define RUCS_DEFS_SVH

`define RUCS_PAGE_W       3
`define RUCS_FACTORY_PAGE 3'h0
`define RUCS_WD_W         16
`define RUCS_WD_RESET     16'hFFFF
`define RUCS_CAUSE_W      3
`define RUCS_CAUSE_NONE   3'h0
`define RUCS_CAUSE_PWRUP  3'h1
`define RUCS_CAUSE_ERROR  3'h2
`define RUCS_CAUSE_WDOG   3'h3
`define RUCS_CAUSE_USER   3'h4

`endif

// ### common/rucs_pkg.sv
/*
  Types for the remote update configuration sequencer.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package rucs_pkg;
  typedef enum logic [2:0] {
    RUCS_IDLE,
    RUCS_LOAD,
    RUCS_WAIT,
    RUCS_USER
  } rucs_state_t;
endpackage
`default_nettype wire

// ### hw/rucs_sequencer.sv
/*
  Remote update configuration sequencer: picks the page to load, runs the
  user watchdog, and falls back to the factory page on a remote-mode application load error.
  Assumes a loader outside that fetches a page on load_req_q and answers
  with load_done (with load_err) once; all inputs synchronous to clk.
*/
// Operation
// - Remote mode powers up from page zero
// - Failed application falls back to factory; a failed local-mode page is retried instead
// - Factory sets next page and watchdog
// - Watchdog expiry records cause, reloads factory
// - Only remote-capable applications restart watchdog
// - Watchdog disabled while factory runs
// - Load error records cause, loads factory; factory and local-mode page errors retry with no cause
// - Factory reads cause, writes next page
// - Clean application load enters user mode
// - Application triggers factory reload after update
// - At most seven application pages
// - Serial and parallel schemes all usable
// - Local mode boots application directly
`timescale 1ns/1ns
`include "rucs_defs.svh"
`default_nettype none
module rucs_sequencer
  import rucs_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       remote_mode,
  input  wire logic [`RUCS_PAGE_W-1:0]    local_page,
  input  wire logic [1:0]                 load_scheme,
  input  wire logic                       ctrl_wr,
  input  wire logic [`RUCS_PAGE_W-1:0]    ctrl_page,
  input  wire logic                       ctrl_wd_en,
  input  wire logic [`RUCS_WD_W-1:0]      ctrl_wd_timeout,
  input  wire logic                       wd_restart,
  input  wire logic                       app_remote_capable,
  input  wire logic                       reconfig_req,
  input  wire logic                       load_done,
  input  wire logic                       load_err,
  output logic                            load_req_q,
  output logic [`RUCS_PAGE_W-1:0]         load_page_q,
  output logic [1:0]                      load_scheme_q,
  output logic                            user_mode_q,
  output logic                            factory_active_q,
  output logic [`RUCS_CAUSE_W-1:0]        status_cause_q,
  output logic [`RUCS_PAGE_W-1:0]         status_page_q,
  output logic                            wd_running_q
);

  // ---------------------------------------------------------------
  // State and control register
  // ---------------------------------------------------------------
  rucs_state_t                state_q;
  logic [`RUCS_PAGE_W-1:0]    next_page_q;
  logic                       wd_en_q;
  logic [`RUCS_WD_W-1:0]      wd_timeout_q;
  logic [`RUCS_WD_W-1:0]      wd_cnt_q;
  logic                       wd_expire;
  logic                       is_factory;
  logic                       boot_q;
  logic                       app_fail;

  // Only a failed application page in remote mode falls back; factory and
  // local pages retry, since there is nothing safer left to load
  function automatic logic app_load_failed(
    input rucs_state_t st,
    input logic        done,
    input logic        err,
    input logic        remote,
    input logic        factory
  );
    return (st == RUCS_WAIT) && done && err && remote && !factory;
  endfunction

  assign is_factory = (load_page_q == `RUCS_FACTORY_PAGE);
  assign app_fail   = app_load_failed(state_q, load_done, load_err, remote_mode, is_factory);
  assign wd_expire  = wd_running_q && (wd_cnt_q == '0);

  // Control register written only while factory image runs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      next_page_q  <= `RUCS_FACTORY_PAGE;
      wd_en_q      <= 1'b0;
      wd_timeout_q <= `RUCS_WD_RESET;
    end else if (ctrl_wr && user_mode_q && factory_active_q) begin
      next_page_q  <= ctrl_page;
      wd_en_q      <= ctrl_wd_en;
      wd_timeout_q <= ctrl_wd_timeout;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Boot latch: power-up cause is recorded on the first cycle after release
  always_ff @(posedge clk) begin
    if (!nrst) begin
      boot_q <= 1'b1;
    end else if (state_q == RUCS_IDLE) begin
      boot_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q          <= RUCS_IDLE;
      load_req_q       <= 1'b0;
      load_page_q      <= `RUCS_FACTORY_PAGE;
      load_scheme_q    <= 2'h0;
      user_mode_q      <= 1'b0;
      factory_active_q <= 1'b0;
    end else begin
      load_req_q <= 1'b0;
      unique case (state_q)
        RUCS_IDLE: begin
          // Any scheme code passes through; loader decides transport
          load_scheme_q <= load_scheme;
          if (remote_mode) begin
            load_page_q <= `RUCS_FACTORY_PAGE;
          end else begin
            load_page_q <= local_page;
          end
          state_q <= RUCS_LOAD;
        end
        RUCS_LOAD: begin
          load_req_q <= 1'b1;
          state_q    <= RUCS_WAIT;
        end
        RUCS_WAIT: begin
          if (load_done) begin
            if (load_err && remote_mode && !is_factory) begin
              load_page_q <= `RUCS_FACTORY_PAGE;
              state_q     <= RUCS_LOAD;
            end else if (load_err) begin
              // Factory or local image failed: retry the same page
              state_q <= RUCS_LOAD;
            end else begin
              user_mode_q      <= 1'b1;
              factory_active_q <= remote_mode && is_factory;
              state_q          <= RUCS_USER;
            end
          end
        end
        RUCS_USER: begin
          if (wd_expire || (remote_mode && reconfig_req)) begin
            user_mode_q      <= 1'b0;
            factory_active_q <= 1'b0;
            state_q          <= RUCS_LOAD;
            if (factory_active_q) begin
              load_page_q <= next_page_q;
            end else begin
              load_page_q <= `RUCS_FACTORY_PAGE;
            end
          end
        end
        default: begin
          state_q <= RUCS_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Status register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      status_cause_q <= `RUCS_CAUSE_NONE;
      status_page_q  <= `RUCS_FACTORY_PAGE;
    end else if (state_q == RUCS_IDLE && boot_q) begin
      status_cause_q <= `RUCS_CAUSE_PWRUP;
    end else if (app_fail) begin
      status_cause_q <= `RUCS_CAUSE_ERROR;
      status_page_q  <= load_page_q;
    end else if (state_q == RUCS_USER && wd_expire) begin
      status_cause_q <= `RUCS_CAUSE_WDOG;
      status_page_q  <= load_page_q;
    end else if (state_q == RUCS_USER && remote_mode && reconfig_req && !factory_active_q) begin
      status_cause_q <= `RUCS_CAUSE_USER;
      status_page_q  <= load_page_q;
    end
  end

  // ---------------------------------------------------------------
  // User watchdog
  // ---------------------------------------------------------------
  // Runs only in a remote-mode application; never under factory image
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wd_running_q <= 1'b0;
      wd_cnt_q     <= `RUCS_WD_RESET;
    end else if (state_q == RUCS_WAIT && load_done && !load_err) begin
      wd_running_q <= wd_en_q && remote_mode && !is_factory;
      wd_cnt_q     <= wd_timeout_q;
    end else if (state_q != RUCS_USER || factory_active_q || wd_expire) begin
      wd_running_q <= 1'b0;
    end else if (wd_running_q) begin
      if (wd_restart && app_remote_capable) begin
        wd_cnt_q <= wd_timeout_q;
      end else begin
        wd_cnt_q <= wd_cnt_q - 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_boot_factory_page: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == RUCS_IDLE && remote_mode) |=> load_page_q == `RUCS_FACTORY_PAGE)
    else $error("remote boot not from factory page");
  a_local_direct: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == RUCS_IDLE && !remote_mode) |=> load_page_q == $past(local_page))
    else $error("local boot page wrong");
  a_error_fallback: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == RUCS_WAIT && load_done && load_err && remote_mode && !is_factory)
      |=> load_page_q == `RUCS_FACTORY_PAGE ##1 load_req_q)
    else $error("no fallback after load error");
  a_error_cause: assert property (@(posedge clk) disable iff (!nrst)
    app_fail |=> status_cause_q == `RUCS_CAUSE_ERROR && status_page_q == $past(load_page_q))
    else $error("load error cause not recorded");
  a_factory_retry: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == RUCS_WAIT && load_done && load_err && (!remote_mode || is_factory))
      |=> $stable(load_page_q) ##1 load_req_q)
    else $error("failed factory or local page not retried");
  a_pwrup_cause: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == RUCS_IDLE && boot_q) |=> status_cause_q == `RUCS_CAUSE_PWRUP)
    else $error("power-up cause not recorded");
  a_scheme_pass: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == RUCS_IDLE) |=> load_scheme_q == $past(load_scheme))
    else $error("loading scheme not passed through");
  a_load_hold: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == RUCS_WAIT && !load_done) |=> $stable(load_page_q) && !user_mode_q)
    else $error("page or mode moved during a load");
  a_local_plain: assert property (@(posedge clk) disable iff (!nrst)
    (user_mode_q && !remote_mode) |-> !factory_active_q && !wd_running_q)
    else $error("local image treated as factory or watched");
  a_user_reload: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == RUCS_USER && remote_mode && reconfig_req && !factory_active_q && !wd_expire)
      |=> load_page_q == `RUCS_FACTORY_PAGE && status_cause_q == `RUCS_CAUSE_USER && !user_mode_q)
    else $error("application reload did not return to factory");

  // ---------------------------------------------------------------
  // Control register, watchdog and user-mode entry checks
  // ---------------------------------------------------------------
  // Writes from an application must not steer the next boot
  a_ctrl_refused: assert property (@(posedge clk) disable iff (!nrst)
    (ctrl_wr && !(user_mode_q && factory_active_q))
      |=> next_page_q == $past(next_page_q) && wd_en_q == $past(wd_en_q)
        && wd_timeout_q == $past(wd_timeout_q))
    else $error("control write accepted outside factory");
  a_ctrl_take: assert property (@(posedge clk) disable iff (!nrst)
    (ctrl_wr && user_mode_q && factory_active_q) |=> next_page_q == $past(ctrl_page))
    else $error("factory control write lost");
  a_wdog_count: assert property (@(posedge clk) disable iff (!nrst)
    (wd_running_q && state_q == RUCS_USER && !factory_active_q && !wd_expire && !wd_restart)
      |=> wd_cnt_q == $past(wd_cnt_q) - 1'b1)
    else $error("watchdog not counting down");
  a_wdog_expiry: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == RUCS_USER && wd_expire) |=> status_cause_q == `RUCS_CAUSE_WDOG
      && load_page_q == `RUCS_FACTORY_PAGE && !user_mode_q)
    else $error("watchdog expiry not handled");
  a_wdog_factory_off: assert property (@(posedge clk) disable iff (!nrst)
    factory_active_q |-> !wd_running_q)
    else $error("watchdog running under factory image");
  a_wdog_restart_ok: assert property (@(posedge clk) disable iff (!nrst)
    (wd_running_q && state_q == RUCS_USER && !factory_active_q && !wd_expire
      && wd_restart && !app_remote_capable) |=> wd_cnt_q == $past(wd_cnt_q) - 1'b1)
    else $error("watchdog restarted by invalid image");
  a_wdog_reload: assert property (@(posedge clk) disable iff (!nrst)
    (wd_running_q && state_q == RUCS_USER && !factory_active_q && !wd_expire
      && wd_restart && app_remote_capable) |=> wd_cnt_q == $past(wd_timeout_q))
    else $error("watchdog not reloaded");
  a_user_entry: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == RUCS_WAIT && load_done && !load_err) |=> user_mode_q)
    else $error("clean load did not enter user mode");
  a_factory_next: assert property (@(posedge clk) disable iff (!nrst)
    (state_q == RUCS_USER && factory_active_q && reconfig_req && !wd_expire)
      |=> load_page_q == $past(next_page_q))
    else $error("factory did not load chosen page");

  c_app_running:  cover property (@(posedge clk) user_mode_q && !factory_active_q && wd_running_q);
  c_wdog_expired: cover property (@(posedge clk) status_cause_q == `RUCS_CAUSE_WDOG);
  c_load_failed:  cover property (@(posedge clk) status_cause_q == `RUCS_CAUSE_ERROR);
  c_local_boot:   cover property (@(posedge clk) user_mode_q && !remote_mode);
  c_user_reload:  cover property (@(posedge clk) status_cause_q == `RUCS_CAUSE_USER);

endmodule
`default_nettype wire

// ### tb/rucs_loader_model.sv
/*
  Paged configuration memory model: answers each load request after a delay.
  Assumes one-cycle request pulses synchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none
module rucs_loader_model #(
  parameter int DELAY = 4
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       load_req,
  input  wire logic [2:0] page,
  input  wire logic       fail_next,
  output logic            load_done,
  output logic            load_err
);
  int   cnt_q;
  logic noise_q = 1'b0;
  always_ff @(posedge clk) begin
    noise_q   <= ~noise_q;
    load_done <= 1'b0;
    load_err  <= noise_q;  // Toggles outside done so stale values never pass
    if (!nrst) cnt_q <= 0;
    else if (load_req) cnt_q <= DELAY;
    else if (cnt_q == 1) begin
      cnt_q     <= 0;
      load_done <= 1'b1;
      load_err  <= fail_next && page != 3'h0;
    end else if (cnt_q > 1) cnt_q <= cnt_q - 1;
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
/*
  Self-checking bench for the configuration sequencer.
  Assumes the loader model answers every request.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rucs_defs.svh"
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin err_count++; $display("[ERR] %0t %s", $time, m); end end
module tb_top;
  import rucs_pkg::*;
  logic        clk = 0, nrst = 0, remote_mode = 1, ctrl_wr = 0, ctrl_wd_en = 0, wd_restart = 0;
  logic        app_cap = 0, reconfig_req = 0, fail_next = 0, load_done, load_err, load_req_q;
  logic        user_mode_q, factory_active_q, wd_running_q;
  logic [2:0]  local_page = 3'h5, ctrl_page = 3'h0, load_page_q, status_cause_q, status_page_q;
  logic [1:0]  load_scheme = 2'h0, load_scheme_q;
  logic [15:0] ctrl_wd_timeout = 16'h0000;
  int          err_count = 0, checks_done = 0, app, tmo, i, s;
  int          exp_q[$];
  always #10 clk = ~clk;
  // Reference model: each load request must fetch the page the rules predict
  always @(posedge clk) begin
    #1;
    if (nrst && load_req_q) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0, "unexpected load")
      else `CHK(load_page_q, 3'(exp_q.pop_front()), "model page")
    end
  end
  rucs_sequencer dut (.clk(clk), .nrst(nrst), .remote_mode(remote_mode), .local_page(local_page),
    .load_scheme(load_scheme), .ctrl_wr(ctrl_wr), .ctrl_page(ctrl_page), .ctrl_wd_en(ctrl_wd_en),
    .ctrl_wd_timeout(ctrl_wd_timeout), .wd_restart(wd_restart), .app_remote_capable(app_cap),
    .reconfig_req(reconfig_req), .load_done(load_done), .load_err(load_err), .load_req_q(load_req_q),
    .load_page_q(load_page_q), .load_scheme_q(load_scheme_q), .user_mode_q(user_mode_q),
    .factory_active_q(factory_active_q), .status_cause_q(status_cause_q), .status_page_q(status_page_q),
    .wd_running_q(wd_running_q));
  rucs_loader_model ldr (.clk(clk), .nrst(nrst), .load_req(load_req_q), .page(load_page_q),
    .fail_next(fail_next), .load_done(load_done), .load_err(load_err));
  task automatic step();
    @(posedge clk);
    #2;
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Bounded wait on load request (1) or user mode (0)
  task automatic wait_sig(input bit req);
    for (i = 0; i < 80 && (req ? load_req_q : user_mode_q) !== 1'b1; i++) step();
    if ((req ? load_req_q : user_mode_q) !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t wait expired", $time);
      finish_test();
    end
  endtask
  task automatic boot(input bit rm, input logic [1:0] sc, input logic [2:0] pg);
    nrst = 0; remote_mode = rm; load_scheme = sc;
    step(); step();
    `CHK(user_mode_q, 1'b0, "reset state")
    exp_q.delete();
    exp_q.push_back(pg);
    nrst = 1;
    step();
    `CHK(load_page_q, pg, "boot page")
    `CHK(status_cause_q, `RUCS_CAUSE_PWRUP, "pwrup cause")
    step();
    `CHK(load_req_q, 1'b1, "boot request")
    wait_sig(0);
    `CHK(load_scheme_q, sc, "scheme")
  endtask
  task automatic ctrl_go(input logic [2:0] pg, input bit en);
    ctrl_page = pg; ctrl_wd_en = en; ctrl_wd_timeout = tmo[15:0]; ctrl_wr = 1;
    exp_q.push_back(pg);
    step();
    ctrl_wr = 0; reconfig_req = 1;
    step();
    reconfig_req = 0;
  endtask
  initial begin
    void'($urandom(63771));
    for (s = 0; s < 4; s++) begin
      boot(1, s[1:0], 3'h0);
      `CHK(factory_active_q, 1'b1, "factory up")
      `CHK(wd_running_q, 1'b0, "wd off in factory")
    end
    $display("test boot done");
    app = 1 + $urandom % 7;
    tmo = 16 + $urandom % 16;
    ctrl_go(app[2:0], 1);
    `CHK(load_page_q, app[2:0], "next page")
    wait_sig(0);
    `CHK(factory_active_q, 1'b0, "app up")
    `CHK(wd_running_q, 1'b1, "wd on")
    app_cap = 1; wd_restart = 1;
    repeat (2 * tmo) step();
    `CHK(user_mode_q, 1'b1, "restart kept app")
    app_cap = 0;
    repeat (tmo - 3) step();
    `CHK(user_mode_q, 1'b1, "early expiry")
    exp_q.push_back(0);
    wait_sig(1);
    wd_restart = 0;
    `CHK(status_cause_q, `RUCS_CAUSE_WDOG, "wd cause")
    `CHK(load_page_q, `RUCS_FACTORY_PAGE, "wd fallback")
    `CHK(status_page_q, app[2:0], "wd page")
    wait_sig(0);
    `CHK(wd_running_q, 1'b0, "wd off again")
    $display("test watchdog done");
    ctrl_go(app[2:0], 0);
    fail_next = 1;
    exp_q.push_back(0);
    step(); step();
    wait_sig(1);
    `CHK(status_cause_q, `RUCS_CAUSE_ERROR, "err cause")
    `CHK(load_page_q, `RUCS_FACTORY_PAGE, "err fallback")
    `CHK(status_page_q, app[2:0], "err page")
    fail_next = 0;
    wait_sig(0);
    `CHK(factory_active_q, 1'b1, "factory after err")
    $display("test load error done");
    ctrl_go(app[2:0], 0);
    wait_sig(0);
    ctrl_page = 3'h0; ctrl_wr = 1;
    exp_q.push_back(0);
    step();
    ctrl_wr = 0; reconfig_req = 1;
    step();
    reconfig_req = 0;
    `CHK(status_cause_q, `RUCS_CAUSE_USER, "user cause")
    `CHK(load_page_q, `RUCS_FACTORY_PAGE, "user reload")
    wait_sig(0);
    reconfig_req = 1;
    step();
    reconfig_req = 0;
    `CHK(load_page_q, app[2:0], "app write refused")
    $display("test user reload done");
    boot(0, 2'h3, local_page);
    `CHK(factory_active_q, 1'b0, "local direct")
    `CHK(exp_q.size(), 0, "loads missing")
    $display("test local done");
    finish_test();
  end
endmodule
`default_nettype wire
